/* src/urx_pkg.sv */
// Constants and types for the receive error, interrupt and wake block
package urx_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  // Oscillator start-up interval, in microseconds
  localparam int unsigned STARTUP_US      = 2;
  localparam int unsigned STARTUP_CYC     = STARTUP_US * CLK_MHZ;
  localparam int unsigned STARTUP_W       = 10;
  localparam logic [9:0]  STARTUP_CNT     = STARTUP_CYC[9:0];
  localparam int unsigned WORD_W          = 9;
  localparam int unsigned FIFO_DEPTH      = 2;
  localparam int unsigned PTR_W           = 1;
  localparam logic [8:0]  DATA_RST        = 9'h000;
  localparam int unsigned STAT_W          = 5;
  // Status layout
  localparam int unsigned ST_FERR         = 0;
  localparam int unsigned ST_PERR         = 1;
  localparam int unsigned ST_OERR         = 2;
  localparam int unsigned ST_RXIF         = 3;
  localparam int unsigned ST_TXIF         = 4;

  typedef enum logic [1:0] {
    URX_RUN  = 2'b00,
    URX_STOP = 2'b01,
    URX_WARM = 2'b10
  } urx_pwr_t;
endpackage

/* src/urx_buf_if.sv */
// Carrier between the control block and the receive word store
`timescale 1ns/1ps
interface urx_buf_if;
  logic       wr;
  logic [8:0] wdata;
  logic       wferr;
  logic       wperr;
  logic       rd;
  logic [8:0] rdata;
  logic       rferr;
  logic       rperr;
  logic       empty;
  logic       full;
  modport ctl (output wr, wdata, wferr, wperr, rd,
               input rdata, rferr, rperr, empty, full);
  modport mem (input wr, wdata, wferr, wperr, rd,
               output rdata, rferr, rperr, empty, full);
endinterface

/* src/urx_rxbuf.sv */
// Two-word receive store keeping each word with its error flags
`timescale 1ns/1ps
module urx_rxbuf
  import urx_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  urx_buf_if.mem    bus
);
  logic [10:0]      mem_r [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_r;
  logic [PTR_W-1:0] rp_r;
  logic [1:0]       cnt_r;
  logic [10:0]      head_r;
  logic             do_wr;
  logic             do_rd;

  assign do_wr     = bus.wr && (cnt_r != 2'd2);
  assign do_rd     = bus.rd && (cnt_r != 2'd0);
  assign bus.empty = (cnt_r == 2'd0);
  assign bus.full  = (cnt_r == 2'd2);
  assign bus.rdata = head_r[8:0];
  assign bus.rferr = head_r[9];
  assign bus.rperr = head_r[10];

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) mem_r[i] <= 11'h000;
    end else if (do_wr) begin
      mem_r[wp_r] <= {bus.wperr, bus.wferr, bus.wdata};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= 2'd0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end

  // Head register tracks the oldest word; written word bypasses when empty
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      head_r <= 11'h000;
    end else if (do_rd && cnt_r == 2'd2) begin
      head_r <= mem_r[rp_r + 1'b1];
    end else if (do_wr && (cnt_r == 2'd0 || (do_rd && cnt_r == 2'd1))) begin
      head_r <= {bus.wperr, bus.wferr, bus.wdata};
    end
  end
endmodule

/* src/urx_core.sv */
// Receive error flags, interrupt request and pin wake-up control
`timescale 1ns/1ps
module urx_core
  import urx_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_clk_run,
  input  wire logic       i_serial_rx_pin,
  input  wire logic       i_word_done,
  input  wire logic [8:0] i_word,
  input  wire logic       i_stop1,
  input  wire logic       i_stop2,
  input  wire logic       i_two_stop,
  input  wire logic       i_par_bit,
  input  wire logic       i_par_odd,
  input  wire logic       i_parity_check_enable,
  input  wire logic       i_nine_bit_select,
  input  wire logic       i_addr_detect_enable,
  input  wire logic       i_pin_wake_enable,
  input  wire logic       i_function_select_bit,
  input  wire logic       i_serial_enable_bit,
  input  wire logic       i_receiver_enable_bit,
  input  wire logic       i_rx_int_enable,
  input  wire logic       i_tx_empty_int_enable,
  input  wire logic       i_tx_idle_int_enable,
  input  wire logic       i_tx_empty_evt,
  input  wire logic       i_tx_idle_evt,
  input  wire logic       i_status_access,
  input  wire logic       i_data_read,
  input  wire logic       i_module_int_enable,
  input  wire logic       i_global_int_enable,
  input  wire logic       i_stack_full,
  output logic            o_irq_n,
  output logic            o_vector_take,
  output logic            o_wake,
  output logic            o_frame_err_flag,
  output logic            o_parity_err_flag,
  output logic            o_overrun_err_flag,
  output logic            o_rx_avail_flag,
  output logic [8:0]      o_serial_data_buffer,
  output logic            o_rx_active
);
  urx_buf_if bif ();

  urx_rxbuf u_buf (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .bus    (bif)
  );

  urx_pwr_t        pwr_r;
  logic [9:0]      warm_r;
  logic            pin_d_r;
  logic            acc_seen_r;
  logic            ovr_r;
  logic            wake_pend_r;
  logic            irq_n_r;
  logic            vec_r;
  logic            fe_w;
  logic            pe_w;
  logic            top_bit;
  logic            word_ok;
  logic            rd_clear;
  logic            avail_evt;
  logic            ovr_evt;
  logic            addr_evt;
  logic            wake_arm;
  logic            fall_edge;
  logic            any_evt;

  function automatic logic parity_bad(input logic [8:0] w, input logic nine,
                                      input logic pb, input logic odd);
    logic p;
    p = ^w[7:0] ^ (nine & w[8]) ^ pb;
    parity_bad = odd ? ~p : p;
  endfunction

  // No word is stored or read while the module clock is stopped or warming up
  assign word_ok   = i_word_done && (pwr_r == URX_RUN);
  assign fe_w      = !i_stop1 || (i_two_stop && !i_stop2);
  assign pe_w      = i_parity_check_enable &&
                     parity_bad(i_word, i_nine_bit_select, i_par_bit,
                                i_par_odd);
  assign top_bit   = i_nine_bit_select ? i_word[8] : i_word[7];
  assign rd_clear  = acc_seen_r && i_data_read && (pwr_r == URX_RUN);
  assign ovr_evt   = word_ok && bif.full;
  assign avail_evt = word_ok && !bif.full &&
                     (!i_addr_detect_enable || top_bit);
  assign addr_evt  = word_ok && !bif.full && i_addr_detect_enable &&
                     top_bit;
  assign wake_arm  = i_pin_wake_enable && i_function_select_bit &&
                     i_serial_enable_bit && i_receiver_enable_bit &&
                     i_rx_int_enable;
  assign fall_edge = pin_d_r && !i_serial_rx_pin;

  assign bif.wr    = word_ok;
  assign bif.wdata = i_word;
  assign bif.wferr = fe_w;
  assign bif.wperr = pe_w;
  assign bif.rd    = rd_clear;

  // Power state: stop, then warm-up count after a pin wake or clock return
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_r  <= URX_RUN;
      warm_r <= 10'h000;
    end else begin
      case (pwr_r)
        URX_RUN: begin
          if (!i_clk_run) pwr_r <= URX_STOP;
        end
        URX_STOP: begin
          if (i_clk_run || (wake_arm && fall_edge)) begin
            pwr_r  <= URX_WARM;
            warm_r <= STARTUP_CNT;
          end
        end
        URX_WARM: begin
          if (warm_r == 10'h001) pwr_r <= URX_RUN;
          warm_r <= warm_r - 10'h001;
        end
        default: pwr_r <= URX_RUN;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) pin_d_r <= 1'b1;
    else         pin_d_r <= i_serial_rx_pin;
  end

  // Wake interrupt remembered through warm-up, delivered afterwards
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_pend_r <= 1'b0;
    end else if (pwr_r == URX_STOP && wake_arm && fall_edge) begin
      wake_pend_r <= 1'b1;
    end else if (pwr_r == URX_RUN) begin
      wake_pend_r <= 1'b0;
    end
  end

  // Status access arms the read-sequence clear; flags ignore software writes
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn)                            acc_seen_r <= 1'b0;
    else if (i_status_access)               acc_seen_r <= 1'b1;
    else if (i_data_read)                   acc_seen_r <= 1'b0;
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn)       ovr_r <= 1'b0;
    else if (ovr_evt)  ovr_r <= 1'b1;
    else if (rd_clear) ovr_r <= 1'b0;
  end

  assign any_evt = (i_tx_empty_evt && i_tx_empty_int_enable) ||
                   (i_tx_idle_evt && i_tx_idle_int_enable) ||
                   (i_rx_int_enable && (avail_evt || ovr_evt)) ||
                   addr_evt ||
                   (wake_pend_r && pwr_r == URX_WARM &&
                    warm_r == 10'h001);

  // Request pulse, one clock, active low
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) irq_n_r <= 1'b1;
    else         irq_n_r <= !any_evt;
  end

  // Module enable masks the vector, not the request; every source vectors only when both enables set and the stack is not full
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) vec_r <= 1'b0;
    else         vec_r <= any_evt && i_global_int_enable &&
                          i_module_int_enable && !i_stack_full;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_n       <= 1'b1;
      o_vector_take <= 1'b0;
      o_wake        <= 1'b0;
    end else begin
      o_irq_n       <= irq_n_r;
      o_vector_take <= vec_r;
      o_wake        <= (pwr_r == URX_STOP) && wake_arm && fall_edge;
    end
  end

  // Registered view of status and head word; frozen while stopped
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_frame_err_flag     <= 1'b0;
      o_parity_err_flag    <= 1'b0;
      o_overrun_err_flag   <= 1'b0;
      o_rx_avail_flag      <= 1'b0;
      o_serial_data_buffer <= DATA_RST;
      o_rx_active          <= 1'b1;
    end else begin
      o_frame_err_flag     <= !bif.empty && bif.rferr;
      o_parity_err_flag    <= !bif.empty && bif.rperr;
      o_overrun_err_flag   <= ovr_r;
      o_rx_avail_flag      <= !bif.empty;
      o_serial_data_buffer <= bif.rdata;
      o_rx_active          <= (pwr_r == URX_RUN);
    end
  end
endmodule

/* tb/urx_core_props.sv */
// Concurrent checks on the receive error, interrupt and wake block
`timescale 1ns/1ps
module urx_core_props (
  input wire logic       i_mclk,
  input wire logic       i_rstn,
  input wire logic       i_word_done,
  input wire logic [8:0] i_word,
  input wire logic       i_stop1,
  input wire logic       i_stop2,
  input wire logic       i_two_stop,
  input wire logic       i_par_bit,
  input wire logic       i_par_odd,
  input wire logic       i_parity_check_enable,
  input wire logic       i_nine_bit_select,
  input wire logic       i_addr_detect_enable,
  input wire logic       i_rx_int_enable,
  input wire logic       i_tx_empty_int_enable,
  input wire logic       i_tx_empty_evt,
  input wire logic       i_data_read,
  input wire logic       o_irq_n,
  input wire logic       o_frame_err_flag,
  input wire logic       o_parity_err_flag,
  input wire logic       o_overrun_err_flag,
  input wire logic       o_rx_avail_flag,
  input wire logic       o_rx_active
);
  logic [1:0] hist_r;
  // Only a word landing in an idle, empty store is judged
  wire logic  fresh = i_word_done && o_rx_active && !o_rx_avail_flag
                      && (hist_r == 2'h0);
  wire logic  msb_hi = i_nine_bit_select ? i_word[8] : i_word[7];
  wire logic  stop_bad = !i_stop1 || (i_two_stop && !i_stop2);
  wire logic  par_bad = ((^i_word[7:0]) ^ (i_nine_bit_select & i_word[8])
                         ^ i_par_bit) != i_par_odd;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn) hist_r <= 2'h0;
    else hist_r <= {hist_r[0], i_word_done};

  chk_irq_one_wide: assert property ($fell(o_irq_n) |=> o_irq_n)
    else $error("irq wider than one cycle");
  chk_tx_empty_irq: assert property (
    i_tx_empty_evt && i_tx_empty_int_enable && o_rx_active |-> ##2 !o_irq_n)
    else $error("tx empty irq missing");
  chk_frame_flag: assert property (
    fresh |-> ##2 o_frame_err_flag == $past(stop_bad, 2))
    else $error("frame flag wrong");
  chk_parity_flag: assert property (
    fresh |-> ##2
      o_parity_err_flag == $past(i_parity_check_enable && par_bad, 2))
    else $error("parity flag wrong");
  chk_addr_irq: assert property (
    fresh && i_addr_detect_enable && msb_hi |-> ##2 !o_irq_n)
    else $error("address irq missing");
  chk_avail_irq: assert property (
    fresh && !i_addr_detect_enable && i_rx_int_enable |-> ##2 !o_irq_n)
    else $error("data irq missing");
  chk_ovr_clear: assert property (
    $fell(o_overrun_err_flag) |-> $past(i_data_read, 2))
    else $error("overrun cleared without read");
  chk_stop_frozen: assert property (
    !o_rx_active [*3] |-> $stable(o_rx_avail_flag)
      && $stable(o_overrun_err_flag))
    else $error("flags moved while stopped");
endmodule

bind urx_core urx_core_props u_props (.*);

/* tb/urx_tx_model.sv */
// Remote serial transmitter: word strobes and receive pin level
`timescale 1ns/1ps
module urx_tx_model (
  input  wire logic       i_mclk,
  output logic            o_word_done,
  output logic [8:0]      o_word,
  output logic            o_stop1,
  output logic            o_stop2,
  output logic            o_par_bit,
  output logic            o_rx_pin
);
  initial begin
    {o_word_done, o_word, o_stop1, o_stop2, o_par_bit} = '0;
    o_rx_pin = 1'b1;
  end
  task automatic send(input logic [8:0] w, input logic s1, s2, p);
    @(posedge i_mclk);
    #1;
    {o_word_done, o_word, o_stop1, o_stop2, o_par_bit} = {1'b1, w, s1, s2, p};
    @(posedge i_mclk);
    #1;
    // Fields are stale once the strobe drops, so show their inverse
    {o_word_done, o_word, o_stop1, o_stop2, o_par_bit} =
      {1'b0, ~w, ~s1, ~s2, ~p};
  endtask
  // Line idles high; a start bit pulls it low
  task automatic start_bit();
    @(posedge i_mclk);
    #1;
    o_rx_pin = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    o_rx_pin = 1'b1;
  endtask
endmodule

/* tb/uart_rx_error_irq_wake_test.sv */
// Self-checking bench for the receive error, interrupt and wake block
`timescale 1ns/1ps
module uart_rx_error_irq_wake_test;
  import urx_pkg::*;
  logic       i_mclk = 1'b0;
  logic       i_rstn = 1'b0;
  logic       i_clk_run, i_two_stop, i_par_odd, i_parity_check_enable;
  logic       i_nine_bit_select, i_addr_detect_enable, i_pin_wake_enable;
  logic       i_function_select_bit, i_serial_enable_bit, i_stack_full;
  logic       i_receiver_enable_bit, i_rx_int_enable, i_tx_idle_evt;
  logic       i_tx_empty_int_enable, i_tx_idle_int_enable, i_tx_empty_evt;
  logic       i_status_access, i_data_read, i_module_int_enable;
  logic       i_global_int_enable, i_serial_rx_pin, i_word_done, i_stop1;
  logic       i_stop2, i_par_bit, o_irq_n, o_vector_take, o_wake;
  logic       o_frame_err_flag, o_parity_err_flag, o_overrun_err_flag;
  logic       o_rx_avail_flag, o_rx_active;
  logic [8:0] i_word, o_serial_data_buffer;
  logic [8:0] adr_w [4] = '{9'h080, 9'h17f, 9'h100, 9'h0ff};
  int         n_errors = 0, cmp_count = 0, n_irq = 0, n_vec = 0, n_wake = 0;
  int         cyc = 0, irq0, vec0, wake0;

  always #2.5 i_mclk = ~i_mclk;

  urx_core dut (.*);
  urx_tx_model mdl (
    .i_mclk      (i_mclk),
    .o_word_done (i_word_done),
    .o_word      (i_word),
    .o_stop1     (i_stop1),
    .o_stop2     (i_stop2),
    .o_par_bit   (i_par_bit),
    .o_rx_pin    (i_serial_rx_pin)
  );

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Pulses counted mid-cycle, clear of the launching edge
  always @(negedge i_mclk) begin
    cyc++;
    n_irq += int'(o_irq_n === 1'b0);
    n_vec += int'(o_vector_take === 1'b1);
    n_wake += int'(o_wake === 1'b1);
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic rd();
    i_status_access = 1'b1;
    tick(1);
    i_status_access = 1'b0;
    i_data_read = 1'b1;
    tick(1);
    i_data_read = 1'b0;
    tick(3);
  endtask

  initial begin
    {i_two_stop, i_par_odd, i_parity_check_enable, i_nine_bit_select,
     i_addr_detect_enable, i_stack_full, i_tx_idle_evt, i_tx_empty_evt,
     i_tx_empty_int_enable, i_tx_idle_int_enable, i_status_access,
     i_data_read} = '0;
    {i_clk_run, i_function_select_bit, i_serial_enable_bit, i_rx_int_enable,
     i_receiver_enable_bit, i_module_int_enable, i_global_int_enable,
     i_pin_wake_enable} = '1;
    tick(5);
    cmp({8'h00, o_irq_n}, 9'h001);
    cmp({8'h00, o_frame_err_flag}, 9'h000);
    cmp(o_serial_data_buffer, DATA_RST);
    i_rstn = 1'b1;
    tick(2);
    irq0 = n_irq;
    vec0 = n_vec;
    mdl.send(9'h025, 1'b1, 1'b1, 1'b0);
    tick(4);
    cmp(o_serial_data_buffer, 9'h025);
    cmp(9'(n_irq - irq0), 9'h001);
    cmp(9'(n_vec - vec0), 9'h001);
    rd();
    cmp({8'h00, o_rx_avail_flag}, 9'h000);
    i_two_stop = 1'b1;
    i_parity_check_enable = 1'b1;
    mdl.send(9'h003, 1'b1, 1'b0, 1'b1);
    mdl.send(9'h003, 1'b1, 1'b1, 1'b0);
    tick(4);
    cmp({7'h00, o_frame_err_flag, o_parity_err_flag}, 9'h003);
    rd();
    cmp({7'h00, o_frame_err_flag, o_parity_err_flag}, 9'h000);
    rd();
    i_parity_check_enable = 1'b0;
    for (int k = 1; k < 4; k++) begin
      mdl.send(9'(k), 1'b1, 1'b1, 1'b0);
    end
    tick(4);
    i_data_read = 1'b1;
    tick(1);
    i_data_read = 1'b0;
    tick(3);
    cmp({8'h00, o_overrun_err_flag}, 9'h001);
    cmp(o_serial_data_buffer, 9'h001);
    rd();
    cmp({8'h00, o_overrun_err_flag}, 9'h000);
    cmp(o_serial_data_buffer, 9'h002);
    rd();
    i_rx_int_enable = 1'b0;
    i_addr_detect_enable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      i_nine_bit_select = k[1];
      irq0 = n_irq;
      mdl.send(adr_w[k], 1'b1, 1'b1, 1'b0);
      tick(4);
      cmp(9'(n_irq - irq0), {8'h00, !k[0]});
      rd();
    end
    i_addr_detect_enable = 1'b0;
    for (int k = 0; k < 32; k++) begin
      {i_global_int_enable, i_module_int_enable} = ~k[4:3];
      i_stack_full = k[2];
      i_tx_empty_int_enable = k[0];
      i_tx_idle_int_enable = !k[0];
      irq0 = n_irq;
      vec0 = n_vec;
      {i_tx_empty_evt, i_tx_idle_evt} = {k[1], !k[1]};
      tick(1);
      {i_tx_empty_evt, i_tx_idle_evt} = 2'b00;
      tick(4);
      cmp(9'(n_irq - irq0), {8'h00, k[0] == k[1]});
      cmp(9'(n_vec - vec0), {8'h00, k[0] == k[1] && k[4:2] == 3'h0});
    end
    {i_module_int_enable, i_stack_full, i_rx_int_enable} = 3'b101;
    for (int k = 0; k < 2; k++) begin
      i_global_int_enable = !k[0];
      // A finished word stays buffered across the stop
      mdl.send(9'h0a5, 1'b1, 1'b1, 1'b0);
      i_clk_run = 1'b0;
      tick(3);
      cmp({8'h00, o_rx_active}, 9'h000);
      irq0 = n_irq;
      vec0 = n_vec;
      wake0 = n_wake;
      mdl.send(9'h011, 1'b1, 1'b1, 1'b0);
      mdl.start_bit();
      i_clk_run = 1'b1;
      mdl.send(9'h022, 1'b1, 1'b1, 1'b0);
      tick(STARTUP_CYC - 20);
      cmp(9'(n_irq - irq0), 9'h000);
      tick(40);
      // Request pulses either way; only the vector needs both enables
      cmp(9'(n_irq - irq0), 9'h001);
      cmp(9'(n_vec - vec0), {8'h00, !k[0]});
      cmp(9'(n_wake - wake0), 9'h001);
      cmp(o_serial_data_buffer, 9'h0a5);
      rd();
      cmp({7'h00, o_rx_avail_flag, o_rx_active}, 9'h001);
    end
    wrap_up();
  end
endmodule
